// >>> logic/dpram_consts.vh
/*
  constants of the dual-port block memory: capacity, width codes, read modes.
  assumes inclusion by the memory core and its port address mapper.
*/
`ifndef DPRAM_CONSTS_VH
`define DPRAM_CONSTS_VH

// ==========================================================================
// capacity
`define MEM_BITS 13'h1000
`define MEM_WORDS 9'h100
`define WORD_BITS 5'h10
`define WORD_IDX_W 8
`define ADDR_W 12
`define DATA_W 16

// ==========================================================================
// port width codes: width = 1 << code
`define WSEL_W1 3'h0
`define WSEL_W2 3'h1
`define WSEL_W4 3'h2
`define WSEL_W8 3'h3
`define WSEL_W16 3'h4

// ==========================================================================
// depth per width code
`define DEPTH_W1 13'h1000
`define DEPTH_W2 13'h0800
`define DEPTH_W4 13'h0400
`define DEPTH_W8 13'h0200
`define DEPTH_W16 13'h0100

// ==========================================================================
// behaviour of the read data on a write
`define RMODE_WRITE_FIRST 2'h0
`define RMODE_READ_FIRST 2'h1
`define RMODE_NO_CHANGE 2'h2

// ==========================================================================
// reset values
`define DOUT_RESET 16'h0000

`endif

// >>> logic/port_map.v
/*
  maps one port's address and width code onto the linear bit array:
  word index, bit offset, lane mask and aligned write data.
  assumes the caller holds the storage as 16-bit words.
*/
`timescale 1ns/1ps
`include "dpram_consts.vh"

module port_map (
	// port configuration
	input wire [2:0] width_sel,
	// port request
	input wire [11:0] addr,
	input wire [15:0] din,
	// mapped result
	output wire [7:0] word_idx,
	output wire [3:0] bit_off,
	output wire [15:0] width_mask,
	output wire [15:0] lane_mask,
	output wire [15:0] wdata_aligned,
	output wire width_ok
);

	// ======================================================================
	// width decode
	reg [15:0] wmask;
	reg ok;
	always @* begin
		ok = 1'b1;
		case (width_sel)
			`WSEL_W1: wmask = 16'h0001;
			`WSEL_W2: wmask = 16'h0003;
			`WSEL_W4: wmask = 16'h000f;
			`WSEL_W8: wmask = 16'h00ff;
			`WSEL_W16: wmask = 16'hffff;
			default: begin
				wmask = 16'h0000;
				ok = 1'b0;
			end
		endcase
	end

	// ======================================================================
	// bit position = addr * width; upper address bits fall off the top
	wire [11:0] bit_pos;
	assign bit_pos = ok ? (addr << width_sel[2:0]) : 12'h000;
	assign word_idx = bit_pos[11:4];
	assign bit_off = bit_pos[3:0];
	assign width_mask = wmask;
	assign lane_mask = wmask << bit_off;
	assign wdata_aligned = (din & wmask) << bit_off;
	assign width_ok = ok;

endmodule // port_map

// >>> logic/dual_port_block_ram.v
/*
  dual-port 4096-bit synchronous memory with independent width per port.
  assumes both ports are driven by fabric logic on clk_sys; inputs are
  synchronous; width codes are held steady while a port is in use.
*/
`timescale 1ns/1ps
`include "dpram_consts.vh"

module dual_port_block_ram (
	// clock and reset
	input wire clk_sys,
	input wire reset_n,
	// port a configuration
	input wire [2:0] a_width_sel,
	input wire [1:0] a_read_mode,
	// port a access
	input wire a_en,
	input wire a_we,
	input wire [11:0] a_addr,
	input wire [15:0] a_din,
	output wire [15:0] a_dout,
	output wire a_cfg_err,
	// port b configuration
	input wire [2:0] b_width_sel,
	input wire [1:0] b_read_mode,
	// port b access
	input wire b_en,
	input wire b_we,
	input wire [11:0] b_addr,
	input wire [15:0] b_din,
	output wire [15:0] b_dout,
	output wire b_cfg_err,
	// shared status
	output wire collision
);

	// ======================================================================
	// storage: one linear bit array held as 16-bit words
	reg [15:0] mem [0:255];

	// ======================================================================
	// helpers
	function [15:0] extract;
		input [15:0] word;
		input [3:0] off;
		input [15:0] wmask;
		begin
			extract = (word >> off) & wmask;
		end
	endfunction

	function [15:0] merge;
		input [15:0] old_word;
		input [15:0] new_bits;
		input [15:0] lane;
		begin
			merge = (old_word & ~lane) | (new_bits & lane);
		end
	endfunction

	// ======================================================================
	// address mapping per port
	wire [7:0] a_word;
	wire [3:0] a_off;
	wire [15:0] a_wmask;
	wire [15:0] a_lane;
	wire [15:0] a_wdata;
	wire a_ok;
	wire [7:0] b_word;
	wire [3:0] b_off;
	wire [15:0] b_wmask;
	wire [15:0] b_lane;
	wire [15:0] b_wdata;
	wire b_ok;

	port_map u_map_a (
		.width_sel(a_width_sel),
		.addr(a_addr),
		.din(a_din),
		.word_idx(a_word),
		.bit_off(a_off),
		.width_mask(a_wmask),
		.lane_mask(a_lane),
		.wdata_aligned(a_wdata),
		.width_ok(a_ok)
	);

	port_map u_map_b (
		.width_sel(b_width_sel),
		.addr(b_addr),
		.din(b_din),
		.word_idx(b_word),
		.bit_off(b_off),
		.width_mask(b_wmask),
		.lane_mask(b_lane),
		.wdata_aligned(b_wdata),
		.width_ok(b_ok)
	);

	// ======================================================================
	// qualified requests; a bad width code disables the port
	wire a_act;
	wire b_act;
	wire a_wr;
	wire b_wr;
	assign a_act = a_en & a_ok;
	assign b_act = b_en & b_ok;
	assign a_wr = a_act & a_we;
	assign b_wr = b_act & b_we;

	// both ports on one word: merged so only port b's bits that overlap port a are lost
	wire same_word;
	wire overlap;
	assign same_word = a_act & b_act & (a_word == b_word);
	assign overlap = same_word & ((a_lane & b_lane) != 16'h0000) & (a_wr | b_wr);

	// ======================================================================
	// write path; on overlapping bits port a wins
	wire [15:0] a_old;
	wire [15:0] b_old;
	wire [15:0] a_new_word;
	wire [15:0] b_new_word;
	wire [15:0] ab_new_word;
	assign a_old = mem[a_word];
	assign b_old = mem[b_word];
	assign a_new_word = merge(a_old, a_wdata, a_lane);
	assign b_new_word = merge(b_old, b_wdata, b_lane);
	assign ab_new_word = merge(b_new_word, a_wdata, a_lane);

	always @(posedge clk_sys) begin
		if (a_wr && b_wr && same_word) begin
			mem[a_word] <= ab_new_word;
		end else begin
			if (a_wr) begin
				mem[a_word] <= a_new_word;
			end
			if (b_wr) begin
				mem[b_word] <= b_new_word;
			end
		end
	end

	// ======================================================================
	// read data selection per mode
	reg [15:0] a_dout_r;
	reg [15:0] a_dout_nxt;
	reg [15:0] b_dout_r;
	reg [15:0] b_dout_nxt;

	always @* begin
		a_dout_nxt = a_dout_r;
		if (a_act) begin
			if (!a_we) begin
				a_dout_nxt = extract(a_old, a_off, a_wmask);
			end else begin
				case (a_read_mode)
					`RMODE_WRITE_FIRST: a_dout_nxt = a_din & a_wmask;
					`RMODE_READ_FIRST: a_dout_nxt = extract(a_old, a_off, a_wmask);
					`RMODE_NO_CHANGE: a_dout_nxt = a_dout_r;
					default: a_dout_nxt = a_din & a_wmask;
				endcase
			end
		end
	end

	always @* begin
		b_dout_nxt = b_dout_r;
		if (b_act) begin
			if (!b_we) begin
				b_dout_nxt = extract(b_old, b_off, b_wmask);
			end else begin
				case (b_read_mode)
					`RMODE_WRITE_FIRST: b_dout_nxt = b_din & b_wmask;
					`RMODE_READ_FIRST: b_dout_nxt = extract(b_old, b_off, b_wmask);
					`RMODE_NO_CHANGE: b_dout_nxt = b_dout_r;
					default: b_dout_nxt = b_din & b_wmask;
				endcase
			end
		end
	end

	// ======================================================================
	// output registers
	reg a_cfg_err_r;
	reg b_cfg_err_r;
	reg collision_r;

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			a_dout_r <= `DOUT_RESET;
			b_dout_r <= `DOUT_RESET;
			a_cfg_err_r <= 1'b0;
			b_cfg_err_r <= 1'b0;
			collision_r <= 1'b0;
		end else begin
			a_dout_r <= a_dout_nxt;
			b_dout_r <= b_dout_nxt;
			a_cfg_err_r <= a_en & ~a_ok;
			b_cfg_err_r <= b_en & ~b_ok;
			collision_r <= overlap;
		end
	end

	assign a_dout = a_dout_r;
	assign b_dout = b_dout_r;
	assign a_cfg_err = a_cfg_err_r;
	assign b_cfg_err = b_cfg_err_r;
	assign collision = collision_r;

endmodule // dual_port_block_ram

// >>> test/dpram_sva.sv
/*
  port checker for the dual-port memory.
  assumes one clk_sys domain and reset_n async low.
*/
`timescale 1ns/1ps
module dpram_sva (
	// clock and reset
	input wire clk_sys,
	input wire reset_n,
	// port a
	input wire [2:0] a_width_sel,
	input wire [1:0] a_read_mode,
	input wire a_en,
	input wire a_we,
	input wire [11:0] a_addr,
	input wire [15:0] a_din,
	input wire [15:0] a_dout,
	input wire a_cfg_err,
	// port b and shared
	input wire [2:0] b_width_sel,
	input wire [1:0] b_read_mode,
	input wire b_en,
	input wire b_we,
	input wire [11:0] b_addr,
	input wire [15:0] b_dout,
	input wire collision
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	sequence wr16_a;
		a_en && a_we && a_width_sel == 3'h4 && a_read_mode == 2'h0;
	endsequence
	sequence clash;
		a_en && a_we && b_en && b_we && a_width_sel == 3'h4 && b_width_sel == 3'h4
			&& a_addr[7:0] == b_addr[7:0];
	endsequence
	err_flag_a: assert property (a_en && a_width_sel > 3'h4 |=> a_cfg_err)
		else $error("no cfg err");
	err_quiet_a: assert property (!(a_en && a_width_sel > 3'h4) |=> !a_cfg_err)
		else $error("spurious cfg err");
	hold_dout_a: assert property (!a_en |=> $stable(a_dout))
		else $error("a dout moved");
	hold_dout_b: assert property (!b_en |=> $stable(b_dout))
		else $error("b dout moved");
	write_first_a: assert property (wr16_a |=> a_dout == $past(a_din))
		else $error("a write data");
	// no-change writes keep the older, possibly wider, read word
	narrow_a: assert property (a_en && a_width_sel == 3'h0 && !(a_we && a_read_mode == 2'h2)
		|=> a_dout[15:1] == 15'h0)
		else $error("a upper bits");
	narrow_b: assert property (b_en && b_width_sel == 3'h3 && !(b_we && b_read_mode == 2'h2)
		|=> b_dout[15:8] == 8'h00)
		else $error("b upper bits");
	clash_flag_a: assert property (clash |=> collision)
		else $error("no collision");
endmodule // dpram_sva

bind dual_port_block_ram dpram_sva i_sva (.clk_sys(clk_sys), .reset_n(reset_n),
	.a_width_sel(a_width_sel), .a_read_mode(a_read_mode), .a_en(a_en), .a_we(a_we),
	.a_addr(a_addr), .a_din(a_din), .a_dout(a_dout), .a_cfg_err(a_cfg_err),
	.b_width_sel(b_width_sel), .b_read_mode(b_read_mode), .b_en(b_en), .b_we(b_we),
	.b_addr(b_addr),
	.b_dout(b_dout), .collision(collision));

// >>> test/fabric_port.sv
/*
  fabric user logic driving one memory port.
  assumes one access per call, launched 1 ns after an edge.
*/
`timescale 1ns/1ps
module fabric_port (
	// clock
	input wire clk_sys,
	// port request
	output reg [2:0] width_sel = 3'h4,
	output reg [1:0] read_mode = 2'h0,
	output reg en = 1'b0,
	output reg we = 1'b0,
	output reg [11:0] addr = 12'h000,
	output reg [15:0] din = 16'h0000
);
	task acc(input [2:0] w, input [11:0] a, input [15:0] d, input wr);
		begin
			@(posedge clk_sys);
			#1;
			width_sel = w;
			en = 1'b1;
			we = wr;
			addr = a;
			din = d;
			@(posedge clk_sys);
			#1;
			en = 1'b0;
			we = 1'b0;
			// released lines no longer show the last value
			addr = ~a;
			din = ~d;
		end
	endtask
endmodule // fabric_port

// >>> test/tb.sv
/*
  self-checking bench for the dual-port memory.
  assumes 100 MHz clk_sys and two fabric_port partners.
*/
`timescale 1ns/1ps
module tb;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	wire [2:0] a_ws, b_ws;
	wire [1:0] a_rm, b_rm;
	wire a_en, a_we, b_en, b_we, a_err, b_err, coll;
	wire [11:0] a_ad, b_ad;
	wire [15:0] a_di, b_di, a_do, b_do;
	logic [61:0] rows [0:7];
	int mismatches = 0;
	int check_count = 0;
	always #5 clk_sys = ~clk_sys;
	fabric_port i_pa (.clk_sys(clk_sys), .width_sel(a_ws), .read_mode(a_rm), .en(a_en),
		.we(a_we), .addr(a_ad), .din(a_di));
	fabric_port i_pb (.clk_sys(clk_sys), .width_sel(b_ws), .read_mode(b_rm), .en(b_en),
		.we(b_we), .addr(b_ad), .din(b_di));
	dual_port_block_ram i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .a_width_sel(a_ws),
		.a_read_mode(a_rm), .a_en(a_en), .a_we(a_we), .a_addr(a_ad), .a_din(a_di),
		.a_dout(a_do), .a_cfg_err(a_err), .b_width_sel(b_ws), .b_read_mode(b_rm),
		.b_en(b_en), .b_we(b_we), .b_addr(b_ad), .b_din(b_di), .b_dout(b_do),
		.b_cfg_err(b_err), .collision(coll));
	task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		begin
			check_count++;
			if (got !== exp) begin
				mismatches++;
				$display("mismatch %s expected %h seen %h", name, exp, got);
			end
		end
	endtask
	task conclude;
		begin
			$display("checks %0d mismatches %0d", check_count, mismatches);
			if (mismatches == 0 && check_count > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	initial begin
		#200000;
		mismatches++;
		conclude;
	end
	initial begin
		// write width, write addr, data, read width, read addr, expected
		rows[0] = {3'h4, 12'h000, 16'hABCD, 3'h2, 12'h001, 16'h000C};
		rows[1] = {3'h4, 12'h000, 16'hABCD, 3'h0, 12'h00F, 16'h0001};
		rows[2] = {3'h3, 12'h001, 16'h005A, 3'h4, 12'h000, 16'h5ACD};
		rows[3] = {3'h4, 12'h0FF, 16'h0000, 3'h4, 12'h0FF, 16'h0000};
		rows[4] = {3'h1, 12'h7FF, 16'h0003, 3'h4, 12'h0FF, 16'hC000};
		rows[5] = {3'h2, 12'h3FF, 16'h0009, 3'h3, 12'h1FF, 16'h0090};
		rows[6] = {3'h0, 12'hFFE, 16'h0001, 3'h4, 12'h0FF, 16'hD000};
		rows[7] = {3'h4, 12'h100, 16'h1234, 3'h4, 12'h000, 16'h1234};
		repeat (8) @(posedge clk_sys);
		chk("dout in reset", 16'h0000, a_do);
		#1;
		reset_n = 1'b1;
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			i_pb.acc(rows[i][61:59], rows[i][58:47], rows[i][46:31], 1'b1);
			i_pa.acc(rows[i][30:28], rows[i][27:16], 16'h0000, 1'b0);
			chk("cross width read", rows[i][15:0], a_do);
		end
		$display("test rows done");
		i_pb.read_mode = 2'h1;
		fork
			i_pa.acc(3'h4, 12'h000, 16'h00FF, 1'b1);
			i_pb.acc(3'h4, 12'h000, 16'hFF00, 1'b1);
		join
		chk("read first", 16'h1234, b_do);
		chk("write first", 16'h00FF, a_do);
		chk("collision", 16'h0001, {15'h0000, coll});
		i_pa.acc(3'h5, 12'h000, 16'h5555, 1'b1);
		chk("cfg error", 16'h0001, {15'h0000, a_err});
		chk("refused hold", 16'h00FF, a_do);
		i_pa.acc(3'h4, 12'h000, 16'h0000, 1'b0);
		chk("winner stored", 16'h00FF, a_do);
		$display("test awkward done");
		i_pb.read_mode = 2'h2;
		i_pb.acc(3'h3, 12'h001, 16'h00AA, 1'b1);
		chk("no change hold", 16'h1234, b_do);
		i_pb.acc(3'h3, 12'h001, 16'h0000, 1'b0);
		chk("no change landed", 16'h00AA, b_do);
		i_pa.read_mode = 2'h3;
		i_pa.acc(3'h4, 12'h002, 16'h4321, 1'b1);
		chk("mode three write", 16'h4321, a_do);
		i_pb.acc(3'h7, 12'h000, 16'hFFFF, 1'b1);
		chk("cfg error b", 16'h0001, {15'h0000, b_err});
		chk("refused hold b", 16'h00AA, b_do);
		$display("test modes done");
		@(posedge clk_sys);
		#1;
		reset_n = 1'b0;
		#1;
		chk("dout a reset", 16'h0000, a_do);
		chk("dout b reset", 16'h0000, b_do);
		repeat (2) @(posedge clk_sys);
		#1;
		reset_n = 1'b1;
		i_pa.acc(3'h4, 12'h000, 16'h0000, 1'b0);
		chk("kept over reset", 16'hAAFF, a_do);
		$display("test second reset done");
		conclude;
	end
endmodule // tb
